// file: hw/pesf_pkg.sv
package pesf_pkg;

  // register byte offsets
  localparam logic [7:0] PESF_OFS_EVENT_SELECTOR0 = 8'h00;
  localparam logic [7:0] PESF_OFS_EVENT_SELECTOR1 = 8'h04;
  localparam logic [7:0] PESF_OFS_EVENT_SELECTOR2 = 8'h08;
  localparam logic [7:0] PESF_OFS_EVENT_SELECTOR3 = 8'h0C;
  localparam logic [7:0] PESF_OFS_EVENT_COUNTER0  = 8'h10;
  localparam logic [7:0] PESF_OFS_EVENT_COUNTER1  = 8'h14;
  localparam logic [7:0] PESF_OFS_EVENT_COUNTER2  = 8'h18;
  localparam logic [7:0] PESF_OFS_EVENT_COUNTER3  = 8'h1C;
  localparam logic [7:0] PESF_OFS_CYCLE_COUNTER   = 8'h20;
  localparam logic [7:0] PESF_OFS_COUNT_ENABLE    = 8'h24;
  localparam logic [7:0] PESF_OFS_OVF_FLAG_SET    = 8'h28;
  localparam logic [7:0] PESF_OFS_OVF_FLAG_CLEAR  = 8'h2C;

  // cycle bit position, event counter count and selector width
  localparam int PESF_CYCLE_BIT  = 31;
  localparam int PESF_NUM_EVCNT  = 4;
  localparam int PESF_SEL_W      = 10;

  // reset values
  localparam logic [9:0]  PESF_RST_SEL   = 10'h000;
  localparam logic [31:0] PESF_RST_CNT   = 32'h0000_0000;
  localparam logic [4:0]  PESF_RST_FLAGS = 5'h00;

  // event selector codes
  localparam logic [9:0] PESF_EV_NONE          = 10'h000;
  localparam logic [9:0] PESF_EV_CYCLE         = 10'h011;
  localparam logic [9:0] PESF_EV_IDLE          = 10'h020;
  localparam logic [9:0] PESF_EV_RUNNING       = 10'h023;
  localparam logic [9:0] PESF_EV_MAC_ANY       = 10'h030;
  localparam logic [9:0] PESF_EV_MAC_8         = 10'h031;
  localparam logic [9:0] PESF_EV_MAC_16        = 10'h032;
  localparam logic [9:0] PESF_EV_AO_ANY        = 10'h040;
  localparam logic [9:0] PESF_EV_AO_8          = 10'h041;
  localparam logic [9:0] PESF_EV_AO_16         = 10'h042;
  localparam logic [9:0] PESF_EV_WD_ACTIVE     = 10'h050;
  localparam logic [9:0] PESF_EV_AXI0_BASE     = 10'h080;
  localparam logic [9:0] PESF_EV_AXI1_BASE     = 10'h180;
  localparam logic [9:0] PESF_EV_LAT_ANY       = 10'h0A0;
  localparam logic [9:0] PESF_EV_LAT_32        = 10'h0A1;
  localparam logic [9:0] PESF_EV_LAT_64        = 10'h0A2;
  localparam logic [9:0] PESF_EV_LAT_128       = 10'h0A3;
  localparam logic [9:0] PESF_EV_LAT_256       = 10'h0A4;
  localparam logic [9:0] PESF_EV_LAT_512       = 10'h0A5;
  localparam logic [9:0] PESF_EV_LAT_1024      = 10'h0A6;
  localparam logic [9:0] PESF_EV_DMA_ECC       = 10'h0B0;
  localparam logic [9:0] PESF_EV_SB_ECC        = 10'h0B1;

  // low nibble of axi port codes
  localparam logic [3:0] PESF_AXI_RD_ACC   = 4'h0;
  localparam logic [3:0] PESF_AXI_RD_BEAT  = 4'h2;
  localparam logic [3:0] PESF_AXI_RD_STALL = 4'h3;
  localparam logic [3:0] PESF_AXI_WR_ACC   = 4'h4;
  localparam logic [3:0] PESF_AXI_WR_BEAT  = 4'h7;
  localparam logic [3:0] PESF_AXI_WA_STALL = 4'h8;
  localparam logic [3:0] PESF_AXI_WD_STALL = 4'h9;
  localparam logic [3:0] PESF_AXI_CLKEN    = 4'hC;
  localparam logic [3:0] PESF_AXI_RD_LIM   = 4'hE;
  localparam logic [3:0] PESF_AXI_WR_LIM   = 4'hF;

  // latency thresholds in cycles
  localparam logic [15:0] PESF_LAT_32   = 16'h0020;
  localparam logic [15:0] PESF_LAT_64   = 16'h0040;
  localparam logic [15:0] PESF_LAT_128  = 16'h0080;
  localparam logic [15:0] PESF_LAT_256  = 16'h0100;
  localparam logic [15:0] PESF_LAT_512  = 16'h0200;
  localparam logic [15:0] PESF_LAT_1024 = 16'h0400;

  typedef struct packed {
    logic arvalid;
    logic arready;
    logic rvalid;
    logic rready;
    logic awvalid;
    logic awready;
    logic wvalid;
    logic wready;
    logic aclken;
    logic rd_limit_stall;
    logic wr_limit_stall;
  } pesf_axi_mon_t;

  typedef struct packed {
    logic        running;
    logic        mac_active;
    logic        mac_8bit;
    logic        mac_16bit;
    logic        ao_active;
    logic        ao_8bit;
    logic        ao_16bit;
    logic        wd_active;
    logic        lat_done;
    logic [15:0] lat_cycles;
    logic        dma_ecc_err;
    logic        sb_ecc_err;
  } pesf_core_mon_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pesf_bus_req_t;

  typedef struct packed {
    logic [3:0][9:0]  sel;
    logic [3:0][31:0] evc;
    logic [31:0]      cyc;
    logic [4:0]       en;
    logic [4:0]       ovf;
    logic [31:0]      rdata;
  } pesf_state_t;

endpackage : pesf_pkg

// file: hw/pesf_top.sv
`timescale 1ns/1ps
module pesf_top
  import pesf_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire pesf_pkg::pesf_bus_req_t  bus_req,
  output logic [31:0]                   rd_data,
  input  wire pesf_pkg::pesf_core_mon_t core_mon,
  input  wire pesf_pkg::pesf_axi_mon_t  axi0_mon,
  input  wire pesf_pkg::pesf_axi_mon_t  axi1_mon,
  output logic [4:0]                    overflow_flags
);

  import pesf_pkg::*;

  pesf_state_t state_ff;
  pesf_state_t nxt_state;

  function automatic logic axi_event(input logic [3:0] code, input pesf_axi_mon_t m);
    logic hit;
    hit = 1'b0;
    case (code)
      PESF_AXI_RD_ACC:   hit = m.arvalid & m.arready;
      PESF_AXI_RD_BEAT:  hit = m.rvalid & m.rready;
      PESF_AXI_RD_STALL: hit = m.arvalid & ~m.arready;
      PESF_AXI_WR_ACC:   hit = m.awvalid & m.awready;
      PESF_AXI_WR_BEAT:  hit = m.wvalid & m.wready;
      PESF_AXI_WA_STALL: hit = m.awvalid & ~m.awready;
      PESF_AXI_WD_STALL: hit = m.wvalid & ~m.wready;
      PESF_AXI_CLKEN:    hit = m.aclken;
      PESF_AXI_RD_LIM:   hit = m.rd_limit_stall;
      PESF_AXI_WR_LIM:   hit = m.wr_limit_stall;
      default:           hit = 1'b0;
    endcase
    return hit;
  endfunction : axi_event

  function automatic logic event_hit(input logic [9:0] sel, input pesf_core_mon_t c,
                                     input pesf_axi_mon_t a0, input pesf_axi_mon_t a1);
    logic hit;
    hit = 1'b0;
    case (sel)
      PESF_EV_NONE:      hit = 1'b0;
      PESF_EV_CYCLE:     hit = 1'b1;
      PESF_EV_IDLE:      hit = ~c.running;
      PESF_EV_RUNNING:   hit = c.running;
      PESF_EV_MAC_ANY:   hit = c.mac_active;
      PESF_EV_MAC_8:     hit = c.mac_active & c.mac_8bit;
      PESF_EV_MAC_16:    hit = c.mac_active & c.mac_16bit;
      PESF_EV_AO_ANY:    hit = c.ao_active;
      PESF_EV_AO_8:      hit = c.ao_active & c.ao_8bit;
      PESF_EV_AO_16:     hit = c.ao_active & c.ao_16bit;
      PESF_EV_WD_ACTIVE: hit = c.wd_active;
      PESF_EV_LAT_ANY:   hit = c.lat_done;
      PESF_EV_LAT_32:    hit = c.lat_done & (c.lat_cycles >= PESF_LAT_32);
      PESF_EV_LAT_64:    hit = c.lat_done & (c.lat_cycles >= PESF_LAT_64);
      PESF_EV_LAT_128:   hit = c.lat_done & (c.lat_cycles >= PESF_LAT_128);
      PESF_EV_LAT_256:   hit = c.lat_done & (c.lat_cycles >= PESF_LAT_256);
      PESF_EV_LAT_512:   hit = c.lat_done & (c.lat_cycles >= PESF_LAT_512);
      PESF_EV_LAT_1024:  hit = c.lat_done & (c.lat_cycles >= PESF_LAT_1024);
      PESF_EV_DMA_ECC:   hit = c.dma_ecc_err;
      PESF_EV_SB_ECC:    hit = c.sb_ecc_err;
      default:
      begin
        if (sel[9:4] == PESF_EV_AXI0_BASE[9:4])
        begin
          hit = axi_event(sel[3:0], a0);
        end
        else if (sel[9:4] == PESF_EV_AXI1_BASE[9:4])
        begin
          hit = axi_event(sel[3:0], a1);
        end
        else
        begin
          hit = 1'b0;
        end
      end
    endcase
    return hit;
  endfunction : event_hit

  logic [31:0] ovf_view;

  always_comb
  begin
    logic [4:0] hw_ovf;
    logic [4:0] set_m;
    logic [4:0] clr_m;
    logic [2:0] idx;
    hw_ovf    = 5'h00;
    set_m     = 5'h00;
    clr_m     = 5'h00;
    idx       = 3'h0;
    nxt_state = state_ff;
    ovf_view  = {state_ff.ovf[4], 27'h000_0000, state_ff.ovf[3:0]};

    // cycle counter
    if (state_ff.en[4])
    begin
      nxt_state.cyc = state_ff.cyc + 32'h0000_0001;
      hw_ovf[4]     = &state_ff.cyc;
    end

    // event counters, each driven by its own selector
    for (int k = 0; k < PESF_NUM_EVCNT; k++)
    begin
      if (state_ff.en[k] && event_hit(state_ff.sel[k], core_mon, axi0_mon, axi1_mon))
      begin
        nxt_state.evc[k] = state_ff.evc[k] + 32'h0000_0001;
        hw_ovf[k]        = &state_ff.evc[k];
      end
    end

    // register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        PESF_OFS_EVENT_SELECTOR0, PESF_OFS_EVENT_SELECTOR1,
        PESF_OFS_EVENT_SELECTOR2, PESF_OFS_EVENT_SELECTOR3:
        begin
          idx = {1'b0, bus_req.addr[3:2]};
          nxt_state.sel[idx[1:0]] = bus_req.wdata[9:0];
        end
        PESF_OFS_EVENT_COUNTER0, PESF_OFS_EVENT_COUNTER1,
        PESF_OFS_EVENT_COUNTER2, PESF_OFS_EVENT_COUNTER3:
        begin
          idx = {1'b0, bus_req.addr[3:2]};
          nxt_state.evc[idx[1:0]] = bus_req.wdata;
        end
        PESF_OFS_CYCLE_COUNTER:
        begin
          nxt_state.cyc = bus_req.wdata;
        end
        PESF_OFS_COUNT_ENABLE:
        begin
          nxt_state.en = {bus_req.wdata[PESF_CYCLE_BIT], bus_req.wdata[3:0]};
        end
        PESF_OFS_OVF_FLAG_SET:
        begin
          set_m = {bus_req.wdata[PESF_CYCLE_BIT], bus_req.wdata[3:0]};
        end
        PESF_OFS_OVF_FLAG_CLEAR:
        begin
          clr_m = {bus_req.wdata[PESF_CYCLE_BIT], bus_req.wdata[3:0]};
        end
        default:
        begin
          idx = 3'h0;
        end
      endcase
    end

    // one shared flag state, set beats clear
    nxt_state.ovf = (state_ff.ovf & ~clr_m) | set_m | hw_ovf;

    // read data only in the cycle after the strobe
    nxt_state.rdata = 32'h0000_0000;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        PESF_OFS_EVENT_SELECTOR0, PESF_OFS_EVENT_SELECTOR1,
        PESF_OFS_EVENT_SELECTOR2, PESF_OFS_EVENT_SELECTOR3:
        begin
          nxt_state.rdata = {22'h00_0000, state_ff.sel[bus_req.addr[3:2]]};
        end
        PESF_OFS_EVENT_COUNTER0, PESF_OFS_EVENT_COUNTER1,
        PESF_OFS_EVENT_COUNTER2, PESF_OFS_EVENT_COUNTER3:
        begin
          nxt_state.rdata = state_ff.evc[bus_req.addr[3:2]];
        end
        PESF_OFS_CYCLE_COUNTER:
        begin
          nxt_state.rdata = state_ff.cyc;
        end
        PESF_OFS_COUNT_ENABLE:
        begin
          nxt_state.rdata = {state_ff.en[4], 27'h000_0000, state_ff.en[3:0]};
        end
        PESF_OFS_OVF_FLAG_SET, PESF_OFS_OVF_FLAG_CLEAR:
        begin
          nxt_state.rdata = ovf_view;
        end
        default:
        begin
          nxt_state.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_ff.sel   <= {PESF_NUM_EVCNT{PESF_RST_SEL}};
      state_ff.evc   <= {PESF_NUM_EVCNT{PESF_RST_CNT}};
      state_ff.cyc   <= PESF_RST_CNT;
      state_ff.en    <= PESF_RST_FLAGS;
      state_ff.ovf   <= PESF_RST_FLAGS;
      state_ff.rdata <= PESF_RST_CNT;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data        = state_ff.rdata;
  assign overflow_flags = state_ff.ovf;

endmodule : pesf_top

// file: dv/pesf_chk_sva.sv
`timescale 1ns/1ps
module pesf_chk
  import pesf_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire pesf_pkg::pesf_bus_req_t bus_req,
  input  wire logic [31:0]             rd_data,
  input  wire logic [4:0]              overflow_flags
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_wr(logic [7:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence

  property p_rst_flags;
    disable iff (1'b0) reset |=> overflow_flags == 5'h00;
  endproperty
  property p_set_cyc;
    s_wr(PESF_OFS_OVF_FLAG_SET) ##0 bus_req.wdata[31] |=> overflow_flags[4];
  endproperty
  property p_set_ev;
    s_wr(PESF_OFS_OVF_FLAG_SET) |=>
      (overflow_flags[3:0] & $past(bus_req.wdata[3:0])) == $past(bus_req.wdata[3:0]);
  endproperty
  property p_hold_cyc;
    overflow_flags[4] &&
      !(bus_req.wr && bus_req.addr == PESF_OFS_OVF_FLAG_CLEAR && bus_req.wdata[31])
      |=> overflow_flags[4];
  endproperty
  property p_hold_ev;
    !(bus_req.wr && bus_req.addr == PESF_OFS_OVF_FLAG_CLEAR) |=>
      (overflow_flags[3:0] & $past(overflow_flags[3:0])) == $past(overflow_flags[3:0]);
  endproperty
  property p_rd_set;
    s_rd(PESF_OFS_OVF_FLAG_SET) |=>
      rd_data == {$past(overflow_flags[4]), 27'h0, $past(overflow_flags[3:0])};
  endproperty
  property p_rd_clr;
    s_rd(PESF_OFS_OVF_FLAG_CLEAR) |=>
      rd_data == {$past(overflow_flags[4]), 27'h0, $past(overflow_flags[3:0])};
  endproperty
  property p_rd_idle;
    !bus_req.rd |=> rd_data == 32'h0000_0000;
  endproperty
  property p_sel_w;
    bus_req.rd && bus_req.addr[7:4] == 4'h0 |=> rd_data[31:10] == 22'h0;
  endproperty

  a_rst_flags: assert property (p_rst_flags) else $error("flags not zero after reset");
  a_set_cyc: assert property (p_set_cyc) else $error("cycle flag not set");
  a_set_ev: assert property (p_set_ev) else $error("event flag not set");
  a_hold_cyc: assert property (p_hold_cyc) else $error("cycle flag lost");
  a_hold_ev: assert property (p_hold_ev) else $error("event flag lost");
  a_rd_set: assert property (p_rd_set) else $error("set view wrong");
  a_rd_clr: assert property (p_rd_clr) else $error("clear view wrong");
  a_sel_w: assert property (p_sel_w) else $error("selector wider than ten bits");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule : pesf_chk

bind pesf_top pesf_chk u_chk (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
  .rd_data(rd_data), .overflow_flags(overflow_flags));

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pesf_pkg::*;
  logic           ref_clk;
  logic           reset;
  pesf_bus_req_t  bus_req;
  logic [31:0]    rd_data;
  pesf_core_mon_t core_mon;
  pesf_axi_mon_t  axi0_mon;
  pesf_axi_mon_t  axi1_mon;
  logic [4:0]     overflow_flags;
  int             bad_count = 0;
  int             cmp_count = 0;
  int             cyc_n = 0;
  int             k;
  logic [31:0]    v;
  logic [7:0]     a;
  logic [31:0]    e;
  string          nm;
  logic [48:0]    pat [6];
  logic [15:0]    tab [$];

  pesf_top uut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .core_mon(core_mon), .axi0_mon(axi0_mon), .axi1_mon(axi1_mon),
    .overflow_flags(overflow_flags));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // one access, then one idle edge so strobes never re-assert in one step
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
    bus_req.addr  <= ad;
    bus_req.wdata <= d;
    bus_req.wr    <= w;
    bus_req.rd    <= !w;
    @(posedge ref_clk);
    bus_req.wr    <= 1'b0;
    bus_req.rd    <= 1'b0;
    #1;
    v = rd_data;
    @(posedge ref_clk);
  endtask : acc

  task automatic rdc(input string n, input logic [7:0] ad, input logic [31:0] x);
    acc(1'b0, ad, 32'h0000_0000);
    chk(n, v, x);
  endtask : rdc

  initial
  begin
    reset = 1'b1;
    bus_req = '0;
    {core_mon, axi0_mon, axi1_mon} = '0;
    pat = '{{9'h1FF, 16'hFFFF, 2'h3, 11'h7FF, 11'h7FF}, {27'h0, 11'h550, 11'h550},
      {27'h0, 11'h0, 11'h7FF}, {9'h0D5, 16'h0040, 2'h2, 11'h0, 11'h0},
      {9'h001, 16'h03FF, 2'h1, 11'h004, 11'h002}, {9'h001, 16'h0400, 2'h0, 22'h0}};
    tab = '{16'h1011, 16'h1023, 16'h0020, 16'h1030, 16'h1040, 16'h1050, 16'h1080,
      16'h1082, 16'h0083, 16'h1084, 16'h1087, 16'h0088, 16'h0089, 16'h108C, 16'h108E,
      16'h108F, 16'h10A0, 16'h10A6, 16'h10B0, 16'h10B1, 16'h0000, 16'h0081, 16'h0181,
      16'h03FF, 16'h118F, 16'h1180, 16'h3020, 16'h3083, 16'h3088, 16'h3089, 16'h3183,
      16'h3188, 16'h3189, 16'h2080, 16'h2082, 16'h2023, 16'h3011, 16'h5180, 16'h5182,
      16'h5184, 16'h5187, 16'h518C, 16'h518E, 16'h4080, 16'h408C, 16'h40A0, 16'h7031,
      16'h6032, 16'h6041, 16'h7042, 16'h7030, 16'h70A2, 16'h60A3, 16'h70B0, 16'h60B1,
      16'h6050, 16'h80A6, 16'h90A5, 16'h908C, 16'h808E, 16'h918E, 16'h90B1, 16'hB0A6,
      16'h70A1, 16'h90A4, 16'h1032, 16'h1041};
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdc("flags_rst", PESF_OFS_OVF_FLAG_SET, 32'h0000_0000);
    rdc("sel_rst", PESF_OFS_EVENT_SELECTOR3, 32'h0000_0000);
    acc(1'b1, PESF_OFS_OVF_FLAG_SET, 32'h8000_0001);
    rdc("flags_both", PESF_OFS_OVF_FLAG_CLEAR, 32'h8000_0001);
    acc(1'b1, PESF_OFS_OVF_FLAG_SET, 32'h7FFF_FFF0);
    rdc("flags_rsvd", PESF_OFS_OVF_FLAG_SET, 32'h8000_0001);
    acc(1'b1, PESF_OFS_OVF_FLAG_SET, 32'h0000_000E);
    chk("flags_pin", {27'h0, overflow_flags}, 32'h0000_001F);
    acc(1'b1, PESF_OFS_OVF_FLAG_CLEAR, 32'h8000_0005);
    rdc("flags_clr", PESF_OFS_OVF_FLAG_SET, 32'h0000_000A);
    acc(1'b1, PESF_OFS_OVF_FLAG_CLEAR, 32'h0000_0000);
    rdc("flags_clr0", PESF_OFS_OVF_FLAG_CLEAR, 32'h0000_000A);
    acc(1'b1, PESF_OFS_EVENT_SELECTOR0, 32'hFFFF_FFFF);
    rdc("sel_width", PESF_OFS_EVENT_SELECTOR0, 32'h0000_03FF);
    rdc("unmapped", 8'h30, 32'h0000_0000);
    $display("test flags done");
    foreach (tab[i])
    begin
      k = i % 4;
      a = PESF_OFS_EVENT_COUNTER0 + 8'(4 * k);
      e = tab[i][12] ? 32'h0000_0005 : 32'h0000_0000;
      nm = $sformatf("event_%h", tab[i][9:0]);
      {core_mon, axi0_mon, axi1_mon} <= pat[tab[i][15:13]];
      acc(1'b1, PESF_OFS_EVENT_SELECTOR0 + 8'(4 * k), {22'h0, tab[i][9:0]});
      acc(1'b1, a, 32'h0000_0000);
      acc(1'b1, PESF_OFS_COUNT_ENABLE, 32'h0000_0001 << k);
      repeat (3) @(posedge ref_clk);
      acc(1'b1, PESF_OFS_COUNT_ENABLE, 32'h0000_0000);
      rdc(nm, a, e);
    end
    $display("test events done");
    acc(1'b1, PESF_OFS_OVF_FLAG_CLEAR, 32'h8000_000F);
    acc(1'b1, PESF_OFS_CYCLE_COUNTER, 32'hFFFF_FFFF);
    acc(1'b1, PESF_OFS_EVENT_COUNTER2, 32'hFFFF_FFFF);
    acc(1'b1, PESF_OFS_EVENT_SELECTOR2, 32'h0000_0011);
    acc(1'b1, PESF_OFS_COUNT_ENABLE, 32'h8000_0004);
    acc(1'b1, PESF_OFS_COUNT_ENABLE, 32'h0000_0000);
    rdc("ovf_wrap", PESF_OFS_OVF_FLAG_SET, 32'h8000_0004);
    rdc("cyc_cnt", PESF_OFS_CYCLE_COUNTER, 32'h0000_0001);
    acc(1'b1, PESF_OFS_OVF_FLAG_CLEAR, 32'h8000_0000);
    rdc("ovf_clr", PESF_OFS_OVF_FLAG_CLEAR, 32'h0000_0004);
    $display("test overflow done");
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdc("flags_rst2", PESF_OFS_OVF_FLAG_SET, 32'h0000_0000);
    chk("pin_rst2", {27'h0, overflow_flags}, 32'h0000_0000);
    $display("test reset done");
    print_verdict();
  end
endmodule : testbench
